// ===== src/mtc_defs.vh
// Constants for the machine trap and trigger register bank.
`ifndef MTC_DEFS_VH
`define MTC_DEFS_VH

`define MTC_ADDR_W            12
`define MTC_ADDR_SCRATCH      12'h340
`define MTC_ADDR_EPC          12'h341
`define MTC_ADDR_CAUSE        12'h342
`define MTC_ADDR_TVAL         12'h343
`define MTC_ADDR_PENDING      12'h344
`define MTC_ADDR_TSEL         12'h7a0
`define MTC_ADDR_TCTRL        12'h7a1
`define MTC_ADDR_BPADDR       12'h7a2
`define MTC_ADDR_TEXTRA       12'h7a3
`define MTC_ADDR_TINFO        12'h7a4
`define MTC_ADDR_MCONTEXT     12'h7a8

`define MTC_RST_SCRATCH       32'h00000000
`define MTC_RST_EPC           32'h00000000
`define MTC_RST_CAUSE_CODE    5'h00
`define MTC_RST_BPADDR        32'h00000000
`define MTC_RST_PENDING       32'h00000000
`define MTC_ZERO              32'h00000000

`define MTC_EPC_KEEP_MASK     32'hfffffffe
`define MTC_CAUSE_IRQ_BIT     31
`define MTC_CAUSE_CODE_MSB    4
`define MTC_CAUSE_PAD_W       26

`define MTC_PEND_MASK         32'hffff0888
`define MTC_PEND_EXT_BIT      11
`define MTC_PEND_TIMER_BIT    7
`define MTC_PEND_SOFT_BIT     3

`define MTC_TCTRL_FIXED       32'h28001040
`define MTC_TCTRL_EXEC_BIT    2
`define MTC_TINFO_VALUE       32'h00000004

`endif

// ===== src/mtc_irq_pending.v
// Read-only pending mirror of the interrupt request lines.
`timescale 1ns/1ps
`include "mtc_defs.vh"

module mtc_irq_pending (
    input  wire        clk,       // Core clock.
    input  wire        srst,      // Synchronous reset, active high.
    input  wire [31:0] irq_lines, // Interrupt request lines.
    output reg  [31:0] pending    // Registered pending view.
);

    // Sampled every edge; no write path exists, so software cannot alter it.
    always @(posedge clk) begin
        if (srst) begin
            pending <= `MTC_RST_PENDING;
        end else begin
            pending <= irq_lines & `MTC_PEND_MASK;
        end
    end

endmodule // mtc_irq_pending

// ===== src/mtc_trigger_match.v
// Exact instruction address comparator for the single breakpoint.
`timescale 1ns/1ps

module mtc_trigger_match (
    input  wire        fetch_valid, // Fetch address is valid.
    input  wire [31:0] fetch_addr,  // Address being fetched.
    input  wire [31:0] bp_addr,     // Breakpoint address.
    input  wire        exec_en,     // Execute matching enabled.
    input  wire        in_debug,    // Core already in debug mode.
    output wire        hit          // Break before this instruction.
);

    // Whole-address compare with no mask; a core already in debug mode
    // must not retrigger on its own debug code.
    assign hit = fetch_valid & exec_en & ~in_debug &
                 (fetch_addr == bp_addr);

endmodule // mtc_trigger_match

// ===== src/mtc_csr_bank.v
// Machine trap and trigger control and status register bank.
`timescale 1ns/1ps
`include "mtc_defs.vh"

module mtc_csr_bank (
    input  wire        REF_CLK,       // Core clock, 100 MHz.
    input  wire        SRST,          // Synchronous reset, active high.
    input  wire        CSR_EN,        // Register access strobe.
    input  wire        CSR_WE,        // Access is a write.
    input  wire [11:0] CSR_ADDR,      // Register address.
    input  wire [31:0] CSR_WDATA,     // Resolved write value.
    input  wire        MACHINE_MODE,  // Core runs in machine mode.
    input  wire        DEBUG_MODE,    // Core runs in debug mode.
    output reg  [31:0] CSR_RDATA,     // Read value.
    output reg         CSR_RVALID,    // Access answered.
    output reg         CSR_ERROR,     // Access refused.
    input  wire        EXC_TAKE,      // Exception or interrupt taken.
    input  wire        EXC_IS_IRQ,    // Trap caused by an interrupt.
    input  wire [4:0]  EXC_CODE,      // Exception code of the trap.
    input  wire [31:0] EXC_PC,        // PC of the trapping instruction.
    input  wire [31:0] HANDLER_PC,    // Trap handler address.
    input  wire        MRET_EXEC,     // Return from machine trap.
    output wire        REDIRECT_VALID,// Fetch redirect request.
    output reg  [31:0] REDIRECT_PC,   // Fetch redirect target.
    input  wire [31:0] IRQ_LINES,     // Interrupt request lines.
    output wire [31:0] IRQ_PENDING,   // Pending view for the core.
    input  wire        FETCH_VALID,   // Fetch address valid.
    input  wire [31:0] FETCH_ADDR,    // Fetch address.
    output wire        DEBUG_HALT_REQ // Enter debug before this fetch.
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_TRAP = 3'h2;
    localparam [2:0] ST_RET  = 3'h4;

    reg  [31:0] scratch_reg;
    reg  [31:0] scratch_next;
    reg  [31:0] epc_reg;
    reg  [31:0] epc_next;
    reg         cause_irq_reg;
    reg         cause_irq_next;
    reg  [4:0]  cause_code_reg;
    reg  [4:0]  cause_code_next;
    reg         exec_en_reg;
    reg         exec_en_next;
    reg  [31:0] bp_addr_reg;
    reg  [31:0] bp_addr_next;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [31:0] redirect_next;
    reg  [31:0] rdata_next;
    reg         mapped;
    wire [31:0] pending;
    wire        priv_ok;
    wire        wr_ok;
    wire        dbg_wr_ok;

    // True when the access is aimed at the given register.
    function hit_addr;
        input [11:0] addr;
        input [11:0] target;
        begin
            hit_addr = (addr == target);
        end
    endfunction

    // Registers of this bank are only reachable from the two privileged
    // modes; anything else is refused and leaves state untouched.
    assign priv_ok   = MACHINE_MODE | DEBUG_MODE;
    assign wr_ok     = CSR_EN & CSR_WE & priv_ok;
    // The breakpoint is a debugger resource, so machine-mode code cannot
    // disturb it even though it may read it.
    assign dbg_wr_ok = wr_ok & DEBUG_MODE;

    mtc_irq_pending u_pending (
        .clk       (REF_CLK),
        .srst      (SRST),
        .irq_lines (IRQ_LINES),
        .pending   (pending)
    );

    mtc_trigger_match u_match (
        .fetch_valid (FETCH_VALID),
        .fetch_addr  (FETCH_ADDR),
        .bp_addr     (bp_addr_reg),
        .exec_en     (exec_en_reg),
        .in_debug    (DEBUG_MODE),
        .hit         (DEBUG_HALT_REQ)
    );

    assign IRQ_PENDING = pending;

    // The match is combinational so the fetch stage can stop the
    // instruction before it issues; a registered hit would be a cycle late.
    // Its only action is the debug entry request.

    always @* begin
        scratch_next = scratch_reg;
        if (wr_ok && hit_addr(CSR_ADDR, `MTC_ADDR_SCRATCH)) begin
            scratch_next = CSR_WDATA;
        end
    end

    // A trap taken in the same cycle as a software write wins, because
    // the handler relies on the saved state of the trap it is serving.
    always @* begin
        epc_next        = epc_reg;
        cause_irq_next  = cause_irq_reg;
        cause_code_next = cause_code_reg;
        if (EXC_TAKE) begin
            epc_next        = EXC_PC & `MTC_EPC_KEEP_MASK;
            cause_irq_next  = EXC_IS_IRQ;
            cause_code_next = EXC_CODE;
        end else if (wr_ok) begin
            if (hit_addr(CSR_ADDR, `MTC_ADDR_EPC)) begin
                epc_next = CSR_WDATA & `MTC_EPC_KEEP_MASK;
            end
            if (hit_addr(CSR_ADDR, `MTC_ADDR_CAUSE)) begin
                // Codes are stored as written; legality is up to software.
                cause_irq_next  = CSR_WDATA[`MTC_CAUSE_IRQ_BIT];
                cause_code_next = CSR_WDATA[`MTC_CAUSE_CODE_MSB:0];
            end
        end
    end

    always @* begin
        exec_en_next = exec_en_reg;
        bp_addr_next = bp_addr_reg;
        if (dbg_wr_ok && hit_addr(CSR_ADDR, `MTC_ADDR_TCTRL)) begin
            exec_en_next = CSR_WDATA[`MTC_TCTRL_EXEC_BIT];
        end
        if (dbg_wr_ok && hit_addr(CSR_ADDR, `MTC_ADDR_BPADDR)) begin
            bp_addr_next = CSR_WDATA;
        end
    end

    // Trap entry has priority over a return arriving in the same cycle.
    always @* begin
        state_next    = ST_IDLE;
        redirect_next = REDIRECT_PC;
        case (state_reg)
            ST_IDLE, ST_TRAP, ST_RET: begin
                if (EXC_TAKE) begin
                    state_next    = ST_TRAP;
                    redirect_next = HANDLER_PC;
                end else if (MRET_EXEC) begin
                    state_next    = ST_RET;
                    redirect_next = epc_reg;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign REDIRECT_VALID = (state_reg == ST_TRAP) | (state_reg == ST_RET);

    always @* begin
        rdata_next = `MTC_ZERO;
        mapped     = 1'b1;
        case (CSR_ADDR)
            `MTC_ADDR_SCRATCH: begin
                rdata_next = scratch_reg;
            end
            `MTC_ADDR_EPC: begin
                rdata_next = epc_reg;
            end
            `MTC_ADDR_CAUSE: begin
                rdata_next = {cause_irq_reg,
                              {`MTC_CAUSE_PAD_W{1'b0}},
                              cause_code_reg};
            end
            `MTC_ADDR_TVAL: begin
                rdata_next = `MTC_ZERO;
            end
            `MTC_ADDR_PENDING: begin
                rdata_next = pending;
            end
            `MTC_ADDR_TSEL: begin
                rdata_next = `MTC_ZERO;
            end
            `MTC_ADDR_TCTRL: begin
                rdata_next = `MTC_TCTRL_FIXED |
                             {29'h0, exec_en_reg, 2'h0};
            end
            `MTC_ADDR_BPADDR: begin
                rdata_next = bp_addr_reg;
            end
            `MTC_ADDR_TEXTRA, `MTC_ADDR_MCONTEXT: begin
                rdata_next = `MTC_ZERO;
            end
            `MTC_ADDR_TINFO: begin
                rdata_next = `MTC_TINFO_VALUE;
            end
            default: begin
                rdata_next = `MTC_ZERO;
                mapped     = 1'b0;
            end
        endcase
    end

    always @(posedge REF_CLK) begin
        if (SRST) begin
            scratch_reg    <= `MTC_RST_SCRATCH;
            epc_reg        <= `MTC_RST_EPC;
            cause_irq_reg  <= 1'b0;
            cause_code_reg <= `MTC_RST_CAUSE_CODE;
            exec_en_reg    <= 1'b0;
            bp_addr_reg    <= `MTC_RST_BPADDR;
            state_reg      <= ST_IDLE;
            REDIRECT_PC    <= `MTC_ZERO;
            CSR_RDATA      <= `MTC_ZERO;
            CSR_RVALID     <= 1'b0;
            CSR_ERROR      <= 1'b0;
        end else begin
            scratch_reg    <= scratch_next;
            epc_reg        <= epc_next;
            cause_irq_reg  <= cause_irq_next;
            cause_code_reg <= cause_code_next;
            exec_en_reg    <= exec_en_next;
            bp_addr_reg    <= bp_addr_next;
            state_reg      <= state_next;
            REDIRECT_PC    <= redirect_next;
            CSR_RVALID     <= CSR_EN;
            // A refused access still answers, with zero data.
            CSR_ERROR      <= CSR_EN & (~priv_ok | ~mapped);
            CSR_RDATA      <= (CSR_EN & priv_ok) ? rdata_next : `MTC_ZERO;
        end
    end

endmodule // mtc_csr_bank

// ===== testbench/mtc_csr_props.sv
// Port checks for the machine trap and trigger register bank.
`timescale 1ns/1ps
`include "mtc_defs.vh"

module mtc_csr_props (
    input wire        REF_CLK,        // Core clock.
    input wire        SRST,           // Synchronous reset.
    input wire        CSR_EN,         // Access strobe.
    input wire        CSR_WE,         // Write qualifier.
    input wire [11:0] CSR_ADDR,       // Register address.
    input wire        MACHINE_MODE,   // Machine mode.
    input wire        DEBUG_MODE,     // Debug mode.
    input wire [31:0] CSR_RDATA,      // Read value.
    input wire        CSR_RVALID,     // Access answered.
    input wire        CSR_ERROR,      // Access refused.
    input wire        EXC_TAKE,       // Trap taken.
    input wire [31:0] HANDLER_PC,     // Handler address.
    input wire        MRET_EXEC,      // Trap return.
    input wire        REDIRECT_VALID, // Redirect pulse.
    input wire [31:0] REDIRECT_PC,    // Redirect target.
    input wire [31:0] IRQ_LINES,      // Request lines.
    input wire [31:0] IRQ_PENDING,    // Pending view.
    input wire        FETCH_VALID,    // Fetch valid.
    input wire        DEBUG_HALT_REQ  // Halt request.
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    wire priv = MACHINE_MODE | DEBUG_MODE;
    wire rd   = CSR_EN & ~CSR_WE & priv;

    rvalid_follow_a: assert property (CSR_EN |=> CSR_RVALID)
        else $error("access not answered");
    tval_zero_a: assert property (rd && CSR_ADDR == `MTC_ADDR_TVAL |=>
        CSR_RDATA == `MTC_ZERO && !CSR_ERROR) else $error("trap value");
    tsel_zero_a: assert property (rd && CSR_ADDR == `MTC_ADDR_TSEL |=>
        CSR_RDATA == `MTC_ZERO) else $error("trigger index");
    tinfo_value_a: assert property (rd && CSR_ADDR == `MTC_ADDR_TINFO |=>
        CSR_RDATA == `MTC_TINFO_VALUE) else $error("type support");
    cause_pad_a: assert property (rd && CSR_ADDR == `MTC_ADDR_CAUSE |=>
        CSR_RDATA[30:5] == 26'h0000000) else $error("cause padding");
    epc_bit_a: assert property (rd && CSR_ADDR == `MTC_ADDR_EPC |=>
        !CSR_RDATA[0]) else $error("epc bit 0");
    no_priv_a: assert property (CSR_EN && !priv |=>
        CSR_ERROR && CSR_RDATA == `MTC_ZERO) else $error("privilege");
    pend_mirror_a: assert property (!SRST |=>
        IRQ_PENDING == ($past(IRQ_LINES) & `MTC_PEND_MASK))
        else $error("pending mirror");
    trap_redir_a: assert property (EXC_TAKE |=> REDIRECT_VALID &&
        REDIRECT_PC == $past(HANDLER_PC)) else $error("trap redirect");
    mret_redir_a: assert property (MRET_EXEC && !EXC_TAKE |=>
        REDIRECT_VALID) else $error("return redirect");
    halt_debug_a: assert property (DEBUG_MODE || !FETCH_VALID |->
        !DEBUG_HALT_REQ) else $error("halt request");

    trap_c: cover property (EXC_TAKE ##1 REDIRECT_VALID);
    mret_c: cover property (MRET_EXEC ##1 REDIRECT_VALID);
    halt_c: cover property (DEBUG_HALT_REQ);
endmodule // mtc_csr_props

bind mtc_csr_bank mtc_csr_props u_props (.REF_CLK(REF_CLK), .SRST(SRST),
    .CSR_EN(CSR_EN), .CSR_WE(CSR_WE), .CSR_ADDR(CSR_ADDR),
    .MACHINE_MODE(MACHINE_MODE), .DEBUG_MODE(DEBUG_MODE),
    .CSR_RDATA(CSR_RDATA), .CSR_RVALID(CSR_RVALID), .CSR_ERROR(CSR_ERROR),
    .EXC_TAKE(EXC_TAKE), .HANDLER_PC(HANDLER_PC), .MRET_EXEC(MRET_EXEC),
    .REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_PC(REDIRECT_PC),
    .IRQ_LINES(IRQ_LINES), .IRQ_PENDING(IRQ_PENDING),
    .FETCH_VALID(FETCH_VALID), .DEBUG_HALT_REQ(DEBUG_HALT_REQ));

// ===== testbench/mtc_csr_bank_bench.sv
// Self-checking bench for the machine trap and trigger register bank.
`timescale 1ns/1ps

module mtc_csr_bank_bench;
    typedef struct packed {
        logic        we;
        logic [1:0]  md;
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } mtc_row_t;
    logic        ref_clk = 1'b0, srst = 1'b1, csr_en = 1'b0, csr_we = 1'b0;
    logic        mm = 1'b0, dm = 1'b0, exc_take = 1'b0, exc_irq = 1'b0;
    logic        mret = 1'b0, fvalid = 1'b0;
    logic [4:0]  exc_code = 5'h00;
    logic [11:0] csr_addr = 12'h000;
    logic [31:0] wdata = 32'h0, exc_pc = 32'h0, hpc = 32'h0;
    logic [31:0] irq_lines = 32'h0, faddr = 32'h0;
    wire  [31:0] rdata, rpc, pend;
    wire         rvalid, err, rvld, halt;
    int          fail_count = 0, n_tests = 0;
    mtc_row_t    rows[$];

    mtc_csr_bank uut (.REF_CLK(ref_clk), .SRST(srst), .CSR_EN(csr_en),
        .CSR_WE(csr_we), .CSR_ADDR(csr_addr), .CSR_WDATA(wdata),
        .MACHINE_MODE(mm), .DEBUG_MODE(dm), .CSR_RDATA(rdata),
        .CSR_RVALID(rvalid), .CSR_ERROR(err), .EXC_TAKE(exc_take),
        .EXC_IS_IRQ(exc_irq), .EXC_CODE(exc_code), .EXC_PC(exc_pc),
        .HANDLER_PC(hpc), .MRET_EXEC(mret), .REDIRECT_VALID(rvld),
        .REDIRECT_PC(rpc), .IRQ_LINES(irq_lines), .IRQ_PENDING(pend),
        .FETCH_VALID(fvalid), .FETCH_ADDR(faddr), .DEBUG_HALT_REQ(halt));

    always #5 ref_clk = ~ref_clk;

    task cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task add(input logic w, input logic [1:0] m, input logic [11:0] a,
             input logic [31:0] d, input logic [31:0] x, input logic e);
        rows.push_back('{w, m, a, d, x, e});
    endtask
    task drive(input mtc_row_t r);
        csr_en <= 1'b1;
        {csr_we, dm, mm, csr_addr, wdata} <= {r.we, r.md, r.addr, r.wd};
    endtask
    // Write answers carry the old contents, so only reads compare data.
    task chk(input mtc_row_t r);
        cmp1("csr_rvalid", 1'b1, rvalid);
        cmp1("csr_error", r.err, err);
        if (!r.we) cmp32("csr_rdata", r.exp, rdata);
    endtask
    task acc(input logic w, input logic [1:0] m, input logic [11:0] a,
             input logic [31:0] d, input logic [31:0] x);
        @(posedge ref_clk);
        drive('{w, m, a, d, x, 1'b0});
        @(posedge ref_clk);
        csr_en <= 1'b0;
        #1 chk('{w, m, a, d, x, 1'b0});
    endtask
    task trap(input logic irq, input logic [4:0] c, input logic [31:0] pc);
        @(posedge ref_clk);
        {exc_take, exc_irq, exc_code, exc_pc} <= {1'b1, irq, c, pc};
        hpc <= pc ^ 32'h00f00000;
        @(posedge ref_clk);
        exc_take <= 1'b0;
        #1 cmp1("redirect_valid", 1'b1, rvld);
        cmp32("redirect_pc", pc ^ 32'h00f00000, rpc);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        summarize;
    end

    initial begin
        logic [31:0] fa [4] = '{32'h1000, 32'h1004, 32'h1001, 32'h1000};
        logic [3:0]  fdm = 4'b1000, fex = 4'b0001;
        add(0, 1, 12'h340, 0, 0, 0);
        add(0, 1, 12'h341, 0, 0, 0);
        add(0, 1, 12'h342, 0, 0, 0);
        add(0, 1, 12'h343, 0, 0, 0);
        add(0, 1, 12'h344, 0, 0, 0);
        add(0, 1, 12'h7a0, 0, 0, 0);
        add(0, 1, 12'h7a1, 0, 32'h28001040, 0);
        add(0, 1, 12'h7a2, 0, 0, 0);
        add(0, 1, 12'h7a4, 0, 32'h4, 0);
        add(1, 1, 12'h340, 32'ha5a55a5a, 0, 0);
        add(0, 1, 12'h340, 0, 32'ha5a55a5a, 0);
        add(1, 1, 12'h341, 32'h12345677, 0, 0);
        add(0, 1, 12'h341, 0, 32'h12345676, 0);
        add(1, 1, 12'h342, 32'hffffffff, 0, 0);
        add(0, 1, 12'h342, 0, 32'h8000001f, 0);
        add(1, 1, 12'h343, 32'hffffffff, 0, 0);
        add(0, 1, 12'h343, 0, 0, 0);
        add(1, 1, 12'h344, 32'hffffffff, 0, 0);
        add(0, 1, 12'h344, 0, 0, 0);
        add(1, 1, 12'h7a0, 32'hffffffff, 0, 0);
        add(0, 1, 12'h7a0, 0, 0, 0);
        add(1, 1, 12'h7a1, 32'hffffffff, 0, 0);
        add(1, 1, 12'h7a2, 32'h1000, 0, 0);
        add(0, 1, 12'h7a1, 0, 32'h28001040, 0);
        add(0, 1, 12'h7a2, 0, 0, 0);
        add(1, 2, 12'h7a1, 32'hffffffff, 0, 0);
        add(1, 2, 12'h7a2, 32'h1000, 0, 0);
        add(0, 2, 12'h7a1, 0, 32'h28001044, 0);
        add(0, 2, 12'h7a2, 0, 32'h1000, 0);
        add(1, 2, 12'h7a3, 32'hffffffff, 0, 0);
        add(1, 2, 12'h7a8, 32'hffffffff, 0, 0);
        add(0, 1, 12'h7a3, 0, 0, 0);
        add(0, 1, 12'h7a8, 0, 0, 0);
        add(0, 1, 12'h345, 0, 0, 1);
        add(0, 0, 12'h340, 0, 0, 1);
        add(1, 0, 12'h340, 32'h1, 0, 1);
        add(0, 1, 12'h340, 0, 32'ha5a55a5a, 0);
        add(0, 0, 12'h7a1, 0, 0, 1);
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge ref_clk);
            drive(rows[i]);
            #1;
            if (i > 0) chk(rows[i-1]);
        end
        @(posedge ref_clk);
        csr_en <= 1'b0;
        #1 chk(rows[rows.size()-1]);
        trap(1'b1, 5'h07, 32'h80000103);
        acc(0, 1, 12'h341, 0, 32'h80000102);
        acc(0, 1, 12'h342, 0, 32'h80000007);
        trap(1'b0, 5'h02, 32'h00000200);
        acc(0, 1, 12'h342, 0, 32'h00000002);
        @(posedge ref_clk);
        mret <= 1'b1;
        @(posedge ref_clk);
        mret <= 1'b0;
        #1 cmp32("redirect_pc", 32'h00000200, rpc);
        cmp1("redirect_valid", 1'b1, rvld);
        @(posedge ref_clk);
        irq_lines <= 32'hffffffff;
        @(posedge ref_clk);
        irq_lines <= 32'h00000818;
        #1 cmp32("irq_pending", 32'hffff0888, pend);
        @(posedge ref_clk);
        #1 cmp32("irq_pending", 32'h00000808, pend);
        acc(0, 1, 12'h344, 0, 32'h00000808);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            {fvalid, faddr, dm} <= {1'b1, fa[i], fdm[i]};
            #1 cmp1("debug_halt_req", fex[i], halt);
        end
        acc(1, 2, 12'h7a1, 32'h0, 0);
        @(posedge ref_clk);
        dm <= 1'b0;
        #1 cmp1("debug_halt_req", 1'b0, halt);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        acc(0, 1, 12'h340, 0, 0);
        acc(0, 1, 12'h7a1, 0, 32'h28001040);
        summarize;
    end
endmodule // mtc_csr_bank_bench
